// ===== acsp_pkg.sv
// Function
// RL1 - Chip select low gates all serial cycles
// RL2 - Frame starts at select fall, rising edge
// RL3 - Select held low streams successive bytes
// RL4 - Select high between bytes keeps position
// RL5 - Select held high releases pins, secondary use
// RL6 - Instruction and data move as 8-bit words
// RL7 - First instruction bit chooses read or write
// RL8 - Readback turns data pin to output
// RL9 - MSB first default, LSB first selectable
// RL10 - Host keeps port idle during sampling
// RL11 - Map split into four address regions
// RL12 - Host writes unassigned bits as zero
// RL13 - Host never writes wholly unassigned locations
// RL14 - Reset loads critical registers with defaults
// RL15 - Local registers steered by channel select
// RL16 - Both selects set writes both copies
// RL17 - Both selects set reads channel A
// RL18 - Global registers ignore channel select
// RL19 - Soft reset write, then recovery wait
// RL20 - Output mode register resets to 0x01
// RL21 - Read/write bit, address, then data bytes
// RL22 - Sample rising edges, drive falling edges
package acsp_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int INSTR_RW_POS = 14;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] ADDR_IFC_A = 12'h000;
  localparam logic [11:0] ADDR_IFC_B = 12'h001;
  localparam logic [11:0] ADDR_DEV_CFG = 12'h002;
  localparam logic [11:0] ADDR_CHIP_TYPE = 12'h003;
  localparam logic [11:0] ADDR_ID_LO = 12'h004;
  localparam logic [11:0] ADDR_ID_HI = 12'h005;
  localparam logic [11:0] ADDR_GRADE = 12'h006;
  localparam logic [11:0] ADDR_CHAN_SEL = 12'h008;
  localparam logic [11:0] ADDR_SCRATCH = 12'h00A;
  localparam logic [11:0] ADDR_SPI_REV = 12'h00B;
  localparam logic [11:0] ADDR_OUT_MODE = 12'h561;

  // ==========================================================
  // Address regions
  localparam logic [11:0] IFC_LO = 12'h000;
  localparam logic [11:0] IFC_HI = 12'h00D;
  localparam logic [11:0] ADC_LO = 12'h015;
  localparam logic [11:0] ADC_HI = 12'h27A;
  localparam logic [11:0] DDC_LO = 12'h300;
  localparam logic [11:0] DDC_HI = 12'h387;
  localparam logic [11:0] OUTR_LO = 12'h550;
  localparam logic [11:0] OUTR_HI = 12'h5C5;

  // ==========================================================
  // Fields and reset values
  localparam int SOFT_RST_HI = 7;
  localparam int LSB_FIRST_HI = 6;
  localparam int ASCEND_HI = 5;
  localparam int ASCEND_LO = 2;
  localparam int LSB_FIRST_LO = 1;
  localparam int SOFT_RST_LO = 0;
  localparam int SINGLE_INSTR = 7;
  localparam int CHAN_A = 0;
  localparam int CHAN_B = 1;
  localparam logic [7:0] IFC_B_MASK = 8'h80;
  localparam logic [1:0] CHAN_SEL_RST = 2'h3;
  localparam logic [7:0] OUT_MODE_RST = 8'h01;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] CHIP_TYPE_VAL = 8'h03;
  localparam logic [7:0] SPI_REV_VAL = 8'h01;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 25000000;
  localparam longint RECOVER_MS = 5;
  localparam int RECOVER_CYCLES = int'((RECOVER_MS * CLK_HZ) / 1000);
  localparam int STALL_CYCLES = 1024;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA = 4'h4,
    ST_STALL = 4'h8
  } acsp_state_t;

endpackage

// ===== acsp_regmem.sv
`timescale 1ns/10ps
module acsp_regmem #(
  parameter int ADDR_W = acsp_pkg::ADDR_W,
  parameter int DATA_W = acsp_pkg::DATA_W
) (
  // Clocking
  input wire logic clock,
  input wire logic ce,
  // Write side, one enable per channel copy
  input wire logic [1:0] we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  // Registered read
  input wire logic rd_bank,
  output logic [DATA_W-1:0] rdata
);

  // ==========================================================
  // Channel copies, one array each so every array has one writer
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic [DATA_W-1:0] mem [2**ADDR_W];
    always_ff @(posedge clock) begin
      if (ce && we[b]) begin
        mem[addr] <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (ce) begin
      rdata <= rd_bank ? g_bank[1].mem[addr] : g_bank[0].mem[addr];
    end
  end

endmodule // acsp_regmem

// ===== acsp_port.sv
`timescale 1ns/10ps
module acsp_port #(
  parameter int RECOVER_CYCLES = acsp_pkg::RECOVER_CYCLES,
  parameter int STALL_LIMIT = acsp_pkg::STALL_CYCLES,
  // Identity values are arbitrary
  parameter logic [7:0] CHIP_ID_LO = 8'h5A,
  parameter logic [7:0] CHIP_ID_HI = 8'hA5,
  parameter logic [7:0] CHIP_GRADE = 8'h30
) (
  // Clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  // Configuration to the converter
  output logic pins_released,
  output logic lsb_first,
  output logic [1:0] chan_sel,
  output logic [7:0] out_mode,
  output logic recover_busy
);

  localparam int RW = $clog2(RECOVER_CYCLES + 1);
  localparam int HW = $clog2(STALL_LIMIT + 1);
  localparam logic [RW-1:0] RECOVER_LOAD = RW'(RECOVER_CYCLES - 1);
  localparam logic [HW-1:0] HI_MAX = HW'(STALL_LIMIT);

  // ==========================================================
  // Address decode helpers
  function automatic logic in_map(input logic [11:0] a);
    in_map = (a >= acsp_pkg::IFC_LO && a <= acsp_pkg::IFC_HI) ||
             (a >= acsp_pkg::ADC_LO && a <= acsp_pkg::ADC_HI) ||
             (a >= acsp_pkg::DDC_LO && a <= acsp_pkg::DDC_HI) ||
             (a >= acsp_pkg::OUTR_LO && a <= acsp_pkg::OUTR_HI); // RL11
  endfunction
  function automatic logic is_local(input logic [11:0] a);
    is_local = (a == acsp_pkg::ADDR_DEV_CFG) ||
               (a >= acsp_pkg::ADC_LO && a <= acsp_pkg::ADC_HI);
  endfunction
  function automatic logic is_flop(input logic [11:0] a);
    case (a)
      acsp_pkg::ADDR_IFC_A, acsp_pkg::ADDR_IFC_B, acsp_pkg::ADDR_CHIP_TYPE,
      acsp_pkg::ADDR_ID_LO, acsp_pkg::ADDR_ID_HI, acsp_pkg::ADDR_GRADE,
      acsp_pkg::ADDR_CHAN_SEL, acsp_pkg::ADDR_SCRATCH, acsp_pkg::ADDR_SPI_REV,
      acsp_pkg::ADDR_OUT_MODE: is_flop = 1'b1;
      default: is_flop = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic sclk_m, sclk_q, sclk_d;
  logic cs_m, cs_q;
  logic sdio_m, sdio_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_m <= 1'b0;
      sclk_q <= 1'b0;
      sclk_d <= 1'b0;
      cs_m <= 1'b1;
      cs_q <= 1'b1;
      sdio_m <= 1'b0;
      sdio_q <= 1'b0;
    end else if (ce) begin
      sclk_m <= sclk;
      sclk_q <= sclk_m;
      sclk_d <= sclk_q;
      cs_m <= serial_select_n;
      cs_q <= cs_m;
      sdio_m <= sdio_in;
      sdio_q <= sdio_m;
    end
  end
  logic rise, fall;
  assign rise = sclk_q && !sclk_d; // RL22
  assign fall = !sclk_q && sclk_d; // RL22

  // ==========================================================
  // Serial engine
  acsp_pkg::acsp_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [15:0] instr_sr, next_instr_sr;
  logic is_read, next_is_read;
  logic [11:0] addr, next_addr, mem_addr;
  logic [7:0] rx_byte, next_rx_byte;
  logic [7:0] tx_byte, next_tx_byte;
  logic load_pend, next_load_pend;
  logic [HW-1:0] hi_cnt, next_hi_cnt;
  logic next_sdio_out, next_sdio_oe, next_pins_released;
  logic ascend;
  logic wr_req;
  logic [7:0] wr_data;
  logic [15:0] instr_full;
  logic [7:0] rx_full;
  logic [11:0] addr_step;
  logic [7:0] rd_value;
  logic [7:0] mem_rdata;
  logic [1:0] mem_we;
  logic rd_bank;

  assign instr_full = {instr_sr[14:0], sdio_q};
  assign rx_full = lsb_first ? {sdio_q, rx_byte[7:1]} : {rx_byte[6:0], sdio_q}; // RL9
  assign addr_step = ascend ? addr + 12'h001 : addr - 12'h001; // RL21

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_instr_sr = instr_sr;
    next_is_read = is_read;
    next_addr = addr;
    next_rx_byte = rx_byte;
    next_tx_byte = tx_byte;
    next_load_pend = 1'b0;
    next_sdio_out = sdio_out;
    next_sdio_oe = sdio_oe;
    next_hi_cnt = cs_q ? ((hi_cnt == HI_MAX) ? hi_cnt : hi_cnt + HW'(1)) : '0;
    next_pins_released = cs_q && (hi_cnt == HI_MAX); // RL5
    wr_req = 1'b0;
    wr_data = rx_full;
    if (load_pend) begin
      next_tx_byte = rd_value;
    end
    if (cs_q) begin
      next_sdio_oe = 1'b0; // RL1 RL5
    end
    case (state)
      acsp_pkg::ST_IDLE: begin
        next_bit_cnt = '0;
        if (!cs_q) begin
          next_state = acsp_pkg::ST_INSTR; // RL2
        end
      end
      acsp_pkg::ST_INSTR: begin
        if (cs_q) begin
          next_state = acsp_pkg::ST_IDLE; // RL1
        end else if (rise) begin
          next_instr_sr = instr_full; // RL6
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == acsp_pkg::INSTR_LAST) begin
            next_is_read = instr_sr[acsp_pkg::INSTR_RW_POS]; // RL7
            next_addr = instr_full[11:0]; // RL21
            next_bit_cnt = '0;
            next_load_pend = 1'b1;
            next_state = acsp_pkg::ST_DATA;
          end
        end
      end
      acsp_pkg::ST_DATA: begin
        if (cs_q) begin
          next_state = (bit_cnt == '0) ? acsp_pkg::ST_STALL : acsp_pkg::ST_IDLE; // RL4
        end else if (rise) begin
          next_rx_byte = rx_full;
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == acsp_pkg::BYTE_LAST) begin
            wr_req = !is_read;
            next_addr = addr_step; // RL3
            next_bit_cnt = '0;
            next_load_pend = is_read;
          end
        end else if (fall && is_read) begin
          next_sdio_oe = 1'b1; // RL8
          next_sdio_out = lsb_first ? tx_byte[0] : tx_byte[7]; // RL9 RL22
          next_tx_byte = lsb_first ? {1'b0, tx_byte[7:1]} : {tx_byte[6:0], 1'b0};
        end
      end
      acsp_pkg::ST_STALL: begin
        if (!cs_q) begin
          next_state = acsp_pkg::ST_DATA; // RL4
          next_sdio_oe = is_read; // RL8
        end else if (hi_cnt == HI_MAX) begin
          next_state = acsp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = acsp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= acsp_pkg::ST_IDLE;
      bit_cnt <= '0;
      instr_sr <= '0;
      is_read <= 1'b0;
      addr <= '0;
      rx_byte <= '0;
      tx_byte <= '0;
      load_pend <= 1'b0;
      hi_cnt <= '0;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      pins_released <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      instr_sr <= next_instr_sr;
      is_read <= next_is_read;
      addr <= next_addr;
      rx_byte <= next_rx_byte;
      tx_byte <= next_tx_byte;
      load_pend <= next_load_pend;
      hi_cnt <= next_hi_cnt;
      sdio_out <= next_sdio_out;
      sdio_oe <= next_sdio_oe;
      pins_released <= next_pins_released;
    end
  end

  // ==========================================================
  // Channel steering into the map memory
  always_comb begin
    // Read port runs one cycle ahead so the registered data meets the prefetch
    mem_addr = wr_req ? addr : next_addr;
    mem_we = '0;
    if (wr_req && in_map(addr) && !is_flop(addr)) begin
      if (is_local(addr)) begin
        mem_we = chan_sel; // RL15 RL16
      end else begin
        mem_we = 2'h3; // RL18
      end
    end
    // Channel B only when A is not selected
    rd_bank = is_local(mem_addr) && !chan_sel[acsp_pkg::CHAN_A] &&
              chan_sel[acsp_pkg::CHAN_B]; // RL17
  end

  acsp_regmem u_mem (
    .clock(clock),
    .ce(ce),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(wr_data),
    .rd_bank(rd_bank),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Critical registers
  logic next_lsb_first, next_ascend, single_instr, next_single_instr;
  logic [1:0] next_chan_sel;
  logic [7:0] scratch, next_scratch, next_out_mode;
  logic [RW-1:0] recover_cnt, next_recover_cnt;
  logic next_recover_busy;
  logic soft_rst_req;

  assign soft_rst_req = wr_req && (addr == acsp_pkg::ADDR_IFC_A) &&
                        (wr_data[acsp_pkg::SOFT_RST_HI] || wr_data[acsp_pkg::SOFT_RST_LO]);

  always_comb begin
    next_lsb_first = lsb_first;
    next_ascend = ascend;
    next_single_instr = single_instr;
    next_chan_sel = chan_sel;
    next_scratch = scratch;
    next_out_mode = out_mode;
    next_recover_cnt = (recover_cnt == '0) ? recover_cnt : recover_cnt - RW'(1);
    next_recover_busy = (recover_cnt != '0);
    if (soft_rst_req) begin
      // Soft reset bits clear themselves: they are never stored
      next_lsb_first = 1'b0; // RL19 RL14
      next_ascend = 1'b0;
      next_single_instr = 1'b0;
      next_chan_sel = acsp_pkg::CHAN_SEL_RST;
      next_scratch = acsp_pkg::SCRATCH_RST;
      next_out_mode = acsp_pkg::OUT_MODE_RST; // RL20
      next_recover_cnt = RECOVER_LOAD; // RL19
      next_recover_busy = 1'b1;
    end else if (wr_req) begin
      case (addr)
        acsp_pkg::ADDR_IFC_A: begin
          // Mirrored halves are ORed so either nibble may be used
          next_lsb_first = wr_data[acsp_pkg::LSB_FIRST_HI] ||
                           wr_data[acsp_pkg::LSB_FIRST_LO]; // RL9
          next_ascend = wr_data[acsp_pkg::ASCEND_HI] || wr_data[acsp_pkg::ASCEND_LO];
        end
        acsp_pkg::ADDR_IFC_B: next_single_instr = wr_data[acsp_pkg::SINGLE_INSTR];
        acsp_pkg::ADDR_CHAN_SEL: next_chan_sel = wr_data[1:0]; // RL15
        acsp_pkg::ADDR_SCRATCH: next_scratch = wr_data;
        acsp_pkg::ADDR_OUT_MODE: next_out_mode = wr_data;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lsb_first <= 1'b0; // RL9 RL14
      ascend <= 1'b0;
      single_instr <= 1'b0;
      chan_sel <= acsp_pkg::CHAN_SEL_RST;
      scratch <= acsp_pkg::SCRATCH_RST;
      out_mode <= acsp_pkg::OUT_MODE_RST; // RL20
      recover_cnt <= '0;
      recover_busy <= 1'b0;
    end else if (ce) begin
      lsb_first <= next_lsb_first;
      ascend <= next_ascend;
      single_instr <= next_single_instr;
      chan_sel <= next_chan_sel;
      scratch <= next_scratch;
      out_mode <= next_out_mode;
      recover_cnt <= next_recover_cnt;
      recover_busy <= next_recover_busy;
    end
  end

  // ==========================================================
  // Readback mux; unmapped locations read as zero
  always_comb begin
    case (addr)
      acsp_pkg::ADDR_IFC_A: begin
        rd_value = '0;
        rd_value[acsp_pkg::LSB_FIRST_HI] = lsb_first;
        rd_value[acsp_pkg::LSB_FIRST_LO] = lsb_first;
        rd_value[acsp_pkg::ASCEND_HI] = ascend;
        rd_value[acsp_pkg::ASCEND_LO] = ascend;
      end
      acsp_pkg::ADDR_IFC_B: rd_value = {single_instr, 7'h00} & acsp_pkg::IFC_B_MASK;
      acsp_pkg::ADDR_CHIP_TYPE: rd_value = acsp_pkg::CHIP_TYPE_VAL;
      acsp_pkg::ADDR_ID_LO: rd_value = CHIP_ID_LO;
      acsp_pkg::ADDR_ID_HI: rd_value = CHIP_ID_HI;
      acsp_pkg::ADDR_GRADE: rd_value = CHIP_GRADE;
      acsp_pkg::ADDR_CHAN_SEL: rd_value = {6'h00, chan_sel};
      acsp_pkg::ADDR_SCRATCH: rd_value = scratch;
      acsp_pkg::ADDR_SPI_REV: rd_value = acsp_pkg::SPI_REV_VAL;
      acsp_pkg::ADDR_OUT_MODE: rd_value = out_mode;
      default: rd_value = in_map(addr) ? mem_rdata : 8'h00; // RL11
    endcase
  end

endmodule // acsp_port

// ===== acsp_monitor.sv
`timescale 1ns/10ps
module acsp_monitor #(
  parameter int RECOVER_CYCLES = 50,
  parameter int STALL_LIMIT = 64
) (
  // Clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial pins
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  // Configuration
  input wire logic pins_released,
  input wire logic lsb_first,
  input wire logic [1:0] chan_sel,
  input wire logic [7:0] out_mode,
  input wire logic recover_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  int hi_cnt;
  int busy_cnt;
  // ========
  // Helper counters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt <= 0;
      busy_cnt <= 0;
    end else if (ce) begin
      hi_cnt <= serial_select_n ? hi_cnt + 1 : 0;
      busy_cnt <= recover_busy ? busy_cnt + 1 : 0;
    end
  end
  // ========
  // Sequences
  sequence sel_idle;
    serial_select_n [*6];
  endsequence
  sequence defaults_seen;
    out_mode == acsp_pkg::OUT_MODE_RST && chan_sel == acsp_pkg::CHAN_SEL_RST && !lsb_first;
  endsequence
  // ========
  // Properties
  a_oe_idle: assert property (sel_idle |-> !sdio_oe)
    else $error("data pin driven with select high");
  a_oe_in_frame: assert property ($rose(sdio_oe) |-> !serial_select_n && !pins_released)
    else $error("data pin turned outside a frame");
  a_out_steady: assert property (sdio_oe && sclk && $past(sclk) |-> $stable(sdio_out))
    else $error("read data moved while serial clock high");
  a_rel_early: assert property ($rose(pins_released) |-> hi_cnt > STALL_LIMIT)
    else $error("pins released too early");
  a_rel_late: assert property (hi_cnt > STALL_LIMIT + 8 |-> pins_released)
    else $error("pins not released");
  a_rel_clear: assert property (pins_released && !serial_select_n |-> ##[1:5] !pins_released)
    else $error("pins stay released in a frame");
  a_rst_values: assert property ($rose(rst_n) |-> defaults_seen)
    else $error("wrong values after reset");
  a_soft_load: assert property ($rose(recover_busy) |-> ##[0:2] defaults_seen)
    else $error("soft reset did not reload defaults");
  a_recover_len: assert property ($fell(recover_busy) |-> busy_cnt == RECOVER_CYCLES)
    else $error("wrong recovery length");
endmodule // acsp_monitor
bind acsp_port acsp_monitor #(.RECOVER_CYCLES(RECOVER_CYCLES), .STALL_LIMIT(STALL_LIMIT))
  acsp_monitor_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk),
  .serial_select_n(serial_select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
  .sdio_oe(sdio_oe), .pins_released(pins_released), .lsb_first(lsb_first),
  .chan_sel(chan_sel), .out_mode(out_mode), .recover_busy(recover_busy));

// ===== acsp_host.sv
`timescale 1ns/10ps
module acsp_host (
  // Serial pins
  output logic sclk,
  output logic serial_select_n,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  logic hd;
  logic [7:0] rd_byte;
  event got;
  // Undriven wire must not hold its last value, so the released host toggles it
  assign sdio_in = sdio_oe ? sdio_out : hd;
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    hd = 1'b0;
  end
  task sel(input logic v);
    #80;
    serial_select_n = v;
    #80;
  endtask
  // Low phase longer than high so read data settles before the sampling edge
  task shift(input logic [7:0] b, input logic ord, input logic rd);
    logic [7:0] r;
    int k;
    for (int i = 0; i < 8; i++) begin
      k = ord ? i : 7 - i;
      sclk = 1'b0;
      hd = rd ? ~hd : b[k];
      #200;
      sclk = 1'b1;
      r[k] = sdio_in;
      #120;
    end
    sclk = 1'b0;
    if (rd) begin
      rd_byte = r;
      ->got;
    end
  endtask
  task instr(input logic rw, input logic [11:0] a);
    shift({rw, 3'h0, a[11:8]}, 1'b0, 1'b0);
    shift(a[7:0], 1'b0, 1'b0);
  endtask
endmodule // acsp_host

// ===== acsp_port_tb.sv
`timescale 1ns/10ps
module acsp_port_tb;
  logic clock, rst_n, ce, lsbm;
  logic sclk, serial_select_n, sdio_in, sdio_out, sdio_oe;
  logic pins_released, lsb_first, recover_busy;
  logic [1:0] chan_sel;
  logic [7:0] out_mode, v;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'h8B27;
  // Single-byte table: read flag, address, data or expectation
  logic [20:0] ops [23] = '{
    {1'b0, 12'h008, 8'h01}, {1'b0, 12'h002, 8'h01}, {1'b0, 12'h008, 8'h02},
    {1'b0, 12'h002, 8'h02}, {1'b1, 12'h002, 8'h02}, {1'b0, 12'h008, 8'h01},
    {1'b1, 12'h002, 8'h01}, {1'b0, 12'h008, 8'h03}, {1'b0, 12'h002, 8'h03},
    {1'b0, 12'h008, 8'h02}, {1'b1, 12'h002, 8'h03}, {1'b0, 12'h002, 8'h02},
    {1'b0, 12'h008, 8'h03}, {1'b1, 12'h002, 8'h03}, {1'b0, 12'h008, 8'h02},
    {1'b0, 12'h00A, 8'h3C}, {1'b0, 12'h008, 8'h01}, {1'b1, 12'h00A, 8'h3C},
    {1'b0, 12'h003, 8'hFC}, {1'b1, 12'h003, 8'h03}, {1'b1, 12'h013, 8'h00},
    {1'b1, 12'h2FF, 8'h00}, {1'b1, 12'h5C6, 8'h00}};
  acsp_port #(.RECOVER_CYCLES(50), .STALL_LIMIT(64)) acsp_port_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .sclk(sclk), .serial_select_n(serial_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .pins_released(pins_released),
    .lsb_first(lsb_first), .chan_sel(chan_sel), .out_mode(out_mode),
    .recover_busy(recover_busy));
  acsp_host acsp_host_inst (.sclk(sclk), .serial_select_n(serial_select_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task test_done;
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Long gap after each frame so the next select low starts a new instruction
  task xfer(input logic rw, input logic [11:0] a, input logic [7:0] d[$], input int gap);
    acsp_host_inst.sel(1'b0);
    acsp_host_inst.instr(rw, a);
    foreach (d[i]) begin
      if (rw) exp_q.push_back(d[i]);
      acsp_host_inst.shift(d[i], lsbm, rw);
      if (gap > 0 && i == 0) begin
        acsp_host_inst.sel(1'b1);
        repeat (gap) @(posedge clock);
        #1;
        acsp_host_inst.sel(1'b0);
      end
    end
    acsp_host_inst.sel(1'b1);
    repeat (80) @(posedge clock);
    #1;
  endtask
  always @(acsp_host_inst.got) chk(acsp_host_inst.rd_byte, exp_q.pop_front());
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    lsbm = 1'b0;
    repeat (8) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (80) @(posedge clock);
    #1 chk(out_mode, acsp_pkg::OUT_MODE_RST);
    chk({6'h00, chan_sel}, 8'h03);
    chk({7'h00, pins_released}, 8'h01);
    v = $random(seed);
    xfer(1'b0, acsp_pkg::ADDR_SCRATCH, {v}, 0);
    xfer(1'b1, acsp_pkg::ADDR_SCRATCH, {v}, 0);
    xfer(1'b1, acsp_pkg::ADDR_SPI_REV, {acsp_pkg::SPI_REV_VAL, v}, 0);
    xfer(1'b1, acsp_pkg::ADDR_SPI_REV, {acsp_pkg::SPI_REV_VAL, v}, 20);
    foreach (ops[i]) xfer(ops[i][20], ops[i][19:8], {ops[i][7:0]}, 0);
    chk({6'h00, chan_sel}, 8'h01);
    v = $random(seed) | 8'h80;
    xfer(1'b0, acsp_pkg::ADDR_OUT_MODE, {v}, 0);
    chk(out_mode, v);
    xfer(1'b0, acsp_pkg::ADDR_IFC_A, {8'h42}, 0);
    lsbm = 1'b1;
    chk({7'h00, lsb_first}, 8'h01);
    xfer(1'b1, acsp_pkg::ADDR_SPI_REV, {acsp_pkg::SPI_REV_VAL}, 0);
    // Soft reset, then freeze the clock enable past the whole recovery span
    acsp_host_inst.sel(1'b0);
    acsp_host_inst.instr(1'b0, acsp_pkg::ADDR_IFC_A);
    acsp_host_inst.shift(8'h81, lsbm, 1'b0);
    @(posedge clock);
    #1 ce = 1'b0;
    repeat (60 + ($random(seed) & 15)) @(posedge clock);
    #1 chk({7'h00, recover_busy}, 8'h01);
    ce = 1'b1;
    acsp_host_inst.sel(1'b1);
    repeat (80) @(posedge clock);
    #1 chk({7'h00, recover_busy}, 8'h00);
    lsbm = 1'b0;
    chk({7'h00, lsb_first}, 8'h00);
    chk(out_mode, acsp_pkg::OUT_MODE_RST);
    acsp_host_inst.shift(8'h00, 1'b0, 1'b0);
    acsp_host_inst.shift(8'h0A, 1'b0, 1'b0);
    acsp_host_inst.shift(8'hFF, 1'b0, 1'b0);
    repeat (80) @(posedge clock);
    #1;
    xfer(1'b1, acsp_pkg::ADDR_SCRATCH, {acsp_pkg::SCRATCH_RST}, 0);
    chk(8'(exp_q.size()), 8'h00);
    test_done;
  end
  initial begin
    #1000000;
    miscompares++;
    test_done;
  end
endmodule // acsp_port_tb
